// ---- common/tmd_defs.svh ----
// Constants for the tuning controller instruction decoder
// Notes on behaviour
// RL1 - Skip on register equal or unequal memory
// RL2 - Skip on register not-below or below memory
// RL3 - Compare memory with immediate, four skip senses
// RL4 - AND or OR immediate into memory
// RL5 - Register becomes register XOR memory
// RL6 - Load register, store register, store immediate
// RL7 - Memory to same-row location indexed by register
// RL8 - Same-row location indexed by register to memory
// RL9 - Copy second column to first, same row
// RL10 - Load synthesizer registers in one instruction
// RL11 - Skip when masked memory bits all one/zero
// RL12 - Jump loads address, sets page zero/one
// RL13 - Call pushes return and page, jumps page zero
// RL14 - Return restores counter; second form also skips
// RL15 - Test-and-clear timer/unlock flags; interval pulse test
// RL16 - Set/clear status word 1; test status word 2
// RL17 - Skip on interrupt pin low, enable pin high
// RL18 - Indirect segment pattern output; digit output
// RL19 - Port in, out, set, clear, test bits
// RL20 - Serial mode load; shift-end test on count
// RL21 - Skip on comparator above or below
// RL22 - Clock stop only while enable pin low
// RL23 - Skipped instruction executes as no-operation
`ifndef TMD_DEFS_SVH
`define TMD_DEFS_SVH

// ----------------------------------------------------------------
// Operation codes
// ----------------------------------------------------------------
`define TMD_OP_MISC 6'h00
`define TMD_OP_SETB 6'h01
`define TMD_OP_JMP1 6'h02
`define TMD_OP_CLRB 6'h03
`define TMD_OP_RET 6'h04
`define TMD_OP_RETS 6'h05
`define TMD_OP_JMP0 6'h06
`define TMD_OP_CALL 6'h07
`define TMD_OP_TSTF 6'h08
`define TMD_OP_TSTT 6'h09
`define TMD_OP_TMZ 6'h0A
`define TMD_OP_TMO 6'h0B
`define TMD_OP_SKIP_IF_MEM_BELOW_IMM 6'h0C
`define TMD_OP_SKIP_IF_MEM_NOT_BELOW_IMM 6'h0D
`define TMD_OP_SKIP_IF_MEM_EQUAL_IMM 6'h0E
`define TMD_OP_SKIP_IF_MEM_UNEQUAL_IMM 6'h0F
`define TMD_OP_ORI 6'h11
`define TMD_OP_MVI 6'h12
`define TMD_OP_ANI 6'h13
`define TMD_OP_DIG 6'h20
`define TMD_OP_SEG 6'h21
`define TMD_OP_OUT 6'h22
`define TMD_OP_HALT 6'h23
`define TMD_OP_ROWCP 6'h24
`define TMD_OP_XOR 6'h25
`define TMD_OP_LD 6'h26
`define TMD_OP_SER 6'h28
`define TMD_OP_TMR 6'h29
`define TMD_OP_UNL 6'h2A
`define TMD_OP_SYN 6'h2B
`define TMD_OP_SLT 6'h2C
`define TMD_OP_SGE 6'h2D
`define TMD_OP_SEQ 6'h2E
`define TMD_OP_SNE 6'h2F
`define TMD_OP_ST 6'h30
`define TMD_OP_INDS 6'h31
`define TMD_OP_IN 6'h32
`define TMD_OP_INDD 6'h33

// ----------------------------------------------------------------
// Sub-field codes
// ----------------------------------------------------------------
`define TMD_SUB_ZERO 4'h0
`define TMD_SUB_ONE 4'h1
`define TMD_SUB_HALT 4'hE
`define TMD_HI_TRUE 2'h2
`define TMD_HI_FALSE 2'h0
`define TMD_SHIFT_END 4'h8

// ----------------------------------------------------------------
// Status word bit positions
// ----------------------------------------------------------------
`define TMD_S1_INTE 0
`define TMD_S1_CARRY 1
`define TMD_S1_BANK 2

// ----------------------------------------------------------------
// Memory layout and reset values
// ----------------------------------------------------------------
`define TMD_REG_ROW 2'h0
`define TMD_DIV_BASE 6'h10
`define TMD_RST_PC 10'h000
`define TMD_RST_NIB 4'h0
`define TMD_STACK_DEPTH 3
`define TMD_SEG_ENTRIES 32

`endif

// ---- common/tmd_pkg.sv ----
// Types shared by the tuning controller instruction decoder
`include "tmd_defs.svh"
package tmd_pkg;
    typedef struct packed {
        logic [5:0] op;
        logic [1:0] dh;
        logic [3:0] dl;
        logic [3:0] lo;
    } tmd_instr_t;

    typedef struct packed {
        logic [15:0] divider;
        logic [3:0] freq_sel;
        logic [3:0] mem_nib;
    } tmd_synth_t;

    typedef enum logic [1:0] {
        TMD_FETCH,
        TMD_EXEC,
        TMD_EXEC2,
        TMD_HALT
    } tmd_state_t;
endpackage

// ---- verilog/tmd_datamem.sv ----
// Data memory: 64 nibbles, two read ports, one write port
`timescale 1ns/1ps
module tmd_datamem import tmd_pkg::*; #(
    parameter int AW = 6,
    parameter int DW = 4
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [AW-1:0] rd_a_addr,
    output logic [DW-1:0] rd_a_data,
    input wire logic [AW-1:0] rd_b_addr,
    output logic [DW-1:0] rd_b_data,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [DW-1:0] wr_data,
    output logic [4*DW-1:0] div_nibbles
);
    logic [DW-1:0] mem [0:(1<<AW)-1];

    assign rd_a_data = mem[rd_a_addr];
    assign rd_b_data = mem[rd_b_addr];

    // ----------------------------------------------------------------
    // Divider nibbles seen by the synthesizer load
    // ----------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_div
            assign div_nibbles[g*DW +: DW] = mem[`TMD_DIV_BASE + AW'(g)];
        end
    endgenerate

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < (1<<AW); i++) begin
                mem[i] <= `TMD_RST_NIB;
            end
        end else if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end
endmodule

// ---- verilog/tmd_decode.sv ----
// Instruction fetch, decode and execute control of the tuning controller
`timescale 1ns/1ps
module tmd_decode import tmd_pkg::*; #(
    parameter int PW = 10,
    parameter logic [7*`TMD_SEG_ENTRIES-1:0] SEG_TABLE = '1
) (
    input wire logic clk,
    input wire logic reset_n,
    output logic prog_req,
    output logic [PW:0] prog_addr,
    input wire logic prog_ack,
    input wire tmd_instr_t prog_data,
    input wire logic irq_n,
    input wire logic chip_enable,
    input wire logic interval_pulse,
    input wire logic timer_event,
    input wire logic unlock_event,
    input wire logic comp_above,
    input wire logic comp_below,
    input wire logic [7:0] shift_count,
    input wire logic [15:0] port_in,
    input wire logic seg_group,
    output logic [15:0] port_out,
    output logic [6:0] segment_out,
    output logic [1:0] digit_out,
    output logic [3:0] serial_mode,
    output tmd_synth_t synth_load,
    output logic synth_strobe,
    output logic [3:0] status1,
    output logic timer_flag,
    output logic unlock_flag,
    output logic clock_stopped
);
    // ----------------------------------------------------------------
    // Mask test helpers
    // ----------------------------------------------------------------
    function automatic logic all_ones(input logic [3:0] v, input logic [3:0] m);
        return (v & m) == m;
    endfunction

    function automatic logic all_zero(input logic [3:0] v, input logic [3:0] m);
        return (v & m) == 4'h0;
    endfunction

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    tmd_state_t state;
    tmd_instr_t ir;
    logic [PW-1:0] pc;
    logic page;
    logic skip_pend;
    logic [PW:0] stack [0:`TMD_STACK_DEPTH-1];
    logic [1:0] sp;
    logic [3:0] ind_col;

    // ----------------------------------------------------------------
    // Field decode
    // ----------------------------------------------------------------
    wire [5:0] op = ir.op;
    wire in_exec = (state == TMD_EXEC);
    wire in_exec2 = (state == TMD_EXEC2);
    wire sub_zero = (ir.dl == `TMD_SUB_ZERO);
    wire is_port_bits = sub_zero;
    wire [PW-1:0] jump_addr = {ir.dh, ir.dl, ir.lo};
    wire [1:0] sp_top = (sp == 2'h0) ? 2'(`TMD_STACK_DEPTH - 1) : sp - 2'h1;
    wire [PW:0] ret_val = stack[sp_top];

    // ----------------------------------------------------------------
    // Memory ports
    // ----------------------------------------------------------------
    logic [3:0] m_val;
    logic [3:0] r_val;
    logic [15:0] div_nib;
    logic mem_we;
    logic [5:0] mem_waddr;
    logic [3:0] mem_wdata;

    wire [5:0] addr_m = {ir.dh, ir.dl};
    wire [5:0] addr_r = {`TMD_REG_ROW, ir.lo};
    wire [5:0] addr_a = in_exec2 ? {ir.dh, ind_col} :
                        (op == `TMD_OP_ROWCP) ? {ir.dh, ir.lo} : addr_m;

    tmd_datamem #(.AW(6), .DW(4)) u_mem (
        .clk(clk),
        .reset_n(reset_n),
        .rd_a_addr(addr_a),
        .rd_a_data(m_val),
        .rd_b_addr(addr_r),
        .rd_b_data(r_val),
        .wr_en(mem_we),
        .wr_addr(mem_waddr),
        .wr_data(mem_wdata),
        .div_nibbles(div_nib)
    );

    // ----------------------------------------------------------------
    // Compare and test terms
    // ----------------------------------------------------------------
    wire [4:0] rm_diff = {1'b0, r_val} - {1'b0, m_val};
    wire rm_borrow = rm_diff[4];
    wire rm_eq = (r_val == m_val);
    wire mi_borrow = (m_val < ir.lo);
    wire mi_eq = (m_val == ir.lo);
    wire [3:0] port_sel = port_in[{ir.dh, 2'b00} +: 4];
    wire [3:0] port_cur = port_out[{ir.dh, 2'b00} +: 4];
    wire [3:0] status2 = {1'b0, status1[`TMD_S1_BANK], chip_enable, ~irq_n};
    wire shift_end = (shift_count[3:0] == `TMD_SHIFT_END);
    wire tip_form = sub_zero && (ir.lo == `TMD_SUB_ZERO);
    wire ser_true = (ir.dh == `TMD_HI_TRUE);
    wire ser_shift = (ir.dl == `TMD_SUB_ONE);

    wire test_true = is_port_bits ? all_ones(port_sel, ir.lo)
                                  : all_ones(status2, ir.dl); // RL16 RL17 RL19
    wire test_false = is_port_bits ? all_zero(port_sel, ir.lo)
                                   : all_zero(status2, ir.dl); // RL17 RL19
    wire ser_skip = ser_shift ? (ser_true ? shift_end : !shift_end) // RL20
                              : (ser_true ? comp_below : comp_above); // RL21

    wire skip_cond =
        (op == `TMD_OP_SEQ) ? rm_eq : // RL1
        (op == `TMD_OP_SNE) ? !rm_eq : // RL1
        (op == `TMD_OP_SGE) ? !rm_borrow : // RL2
        (op == `TMD_OP_SLT) ? rm_borrow : // RL2
        (op == `TMD_OP_SKIP_IF_MEM_EQUAL_IMM) ? mi_eq : // RL3
        (op == `TMD_OP_SKIP_IF_MEM_UNEQUAL_IMM) ? !mi_eq : // RL3
        (op == `TMD_OP_SKIP_IF_MEM_NOT_BELOW_IMM) ? !mi_borrow : // RL3
        (op == `TMD_OP_SKIP_IF_MEM_BELOW_IMM) ? mi_borrow : // RL3
        (op == `TMD_OP_TMO) ? all_ones(m_val, ir.lo) : // RL11
        (op == `TMD_OP_TMZ) ? all_zero(m_val, ir.lo) : // RL11
        (op == `TMD_OP_RETS) ? 1'b1 : // RL14
        (op == `TMD_OP_TMR) ? (tip_form ? !interval_pulse : !timer_flag) : // RL15
        (op == `TMD_OP_UNL) ? !unlock_flag : // RL15
        (op == `TMD_OP_TSTT) ? test_true :
        (op == `TMD_OP_TSTF) ? test_false :
        (op == `TMD_OP_SER) ? ser_skip : 1'b0;

    // ----------------------------------------------------------------
    // Memory write selection
    // ----------------------------------------------------------------
    wire wr_mem = (op == `TMD_OP_ANI) || (op == `TMD_OP_ORI) || (op == `TMD_OP_ST)
                  || (op == `TMD_OP_MVI) || (op == `TMD_OP_ROWCP);
    wire wr_reg = (op == `TMD_OP_XOR) || (op == `TMD_OP_LD) || (op == `TMD_OP_IN);
    wire wr_ind = (op == `TMD_OP_INDD);
    wire needs_ind = (op == `TMD_OP_INDS) || (op == `TMD_OP_SEG);

    wire [3:0] wdata_exec =
        (op == `TMD_OP_ANI) ? (m_val & ir.lo) : // RL4
        (op == `TMD_OP_ORI) ? (m_val | ir.lo) : // RL4
        (op == `TMD_OP_XOR) ? (r_val ^ m_val) : // RL5
        (op == `TMD_OP_ST) ? r_val : // RL6
        (op == `TMD_OP_MVI) ? ir.lo : // RL6
        (op == `TMD_OP_IN) ? port_sel : // RL19
        m_val; // RL6 RL7 RL9

    assign mem_we = (in_exec && (wr_mem || wr_reg || wr_ind))
                    || (in_exec2 && (op == `TMD_OP_INDS));
    assign mem_waddr = in_exec2 ? addr_m : // RL8
                       wr_reg ? addr_r :
                       wr_ind ? {ir.dh, r_val} : // RL7
                       addr_m; // RL9
    assign mem_wdata = in_exec2 ? m_val : wdata_exec; // RL8

    // ----------------------------------------------------------------
    // Segment pattern lookup
    // ----------------------------------------------------------------
    wire [4:0] seg_idx = {seg_group, m_val};
    wire [6:0] seg_pat = SEG_TABLE[7*seg_idx +: 7];

    // ----------------------------------------------------------------
    // Fetch handshake
    // ----------------------------------------------------------------
    assign prog_req = (state == TMD_FETCH);
    assign prog_addr = {page, pc};
    assign clock_stopped = (state == TMD_HALT);

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    tmd_state_t next_state;
    wire halt_req = (op == `TMD_OP_HALT) && (ir.dl == `TMD_SUB_HALT)
                    && (ir.lo == `TMD_SUB_HALT) && !chip_enable; // RL22
    assign next_state =
        (state == TMD_FETCH) ? ((prog_ack && !skip_pend) ? TMD_EXEC : TMD_FETCH) : // RL23
        (state == TMD_EXEC) ? (needs_ind ? TMD_EXEC2 :
                               halt_req ? TMD_HALT : TMD_FETCH) :
        (state == TMD_HALT) ? (chip_enable ? TMD_FETCH : TMD_HALT) :
        TMD_FETCH;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= TMD_FETCH;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ir <= '0;
            skip_pend <= 1'b0;
        end else if (prog_req && prog_ack) begin
            ir <= prog_data;
            skip_pend <= 1'b0; // RL23
        end else if (in_exec) begin
            skip_pend <= skip_cond;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ind_col <= `TMD_RST_NIB;
        end else if (in_exec) begin
            ind_col <= r_val;
        end
    end

    // ----------------------------------------------------------------
    // Program counter, page and stack
    // ----------------------------------------------------------------
    wire do_jump = in_exec && ((op == `TMD_OP_JMP0) || (op == `TMD_OP_JMP1)
                               || (op == `TMD_OP_CALL));
    wire do_ret = in_exec && ((op == `TMD_OP_RET) || (op == `TMD_OP_RETS));
    wire do_call = in_exec && (op == `TMD_OP_CALL);

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pc <= `TMD_RST_PC;
            page <= 1'b0;
        end else if (prog_req && prog_ack) begin
            pc <= pc + PW'(1);
        end else if (do_jump) begin
            pc <= jump_addr; // RL12 RL13
            page <= (op == `TMD_OP_JMP1); // RL12
        end else if (do_ret) begin
            {page, pc} <= ret_val; // RL14
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sp <= 2'h0;
            for (int i = 0; i < `TMD_STACK_DEPTH; i++) begin
                stack[i] <= '0;
            end
        end else if (do_call) begin
            stack[sp] <= {page, pc}; // RL13
            sp <= (sp == 2'(`TMD_STACK_DEPTH - 1)) ? 2'h0 : sp + 2'h1;
        end else if (do_ret) begin
            sp <= sp_top; // RL14
        end
    end

    // ----------------------------------------------------------------
    // Timer and unlock flags, set wins over clear
    // ----------------------------------------------------------------
    wire clr_timer = in_exec && (op == `TMD_OP_TMR) && !tip_form; // RL15
    wire clr_unlock = in_exec && (op == `TMD_OP_UNL); // RL15

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            timer_flag <= 1'b0;
            unlock_flag <= 1'b0;
        end else begin
            timer_flag <= timer_event | (timer_flag & !clr_timer);
            unlock_flag <= unlock_event | (unlock_flag & !clr_unlock);
        end
    end

    // ----------------------------------------------------------------
    // Status word 1 and ports
    // ----------------------------------------------------------------
    wire set_bits = in_exec && (op == `TMD_OP_SETB);
    wire clr_bits = in_exec && (op == `TMD_OP_CLRB);

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            status1 <= `TMD_RST_NIB;
        end else if (set_bits && !is_port_bits) begin
            status1 <= status1 | ir.dl; // RL16
        end else if (clr_bits && !is_port_bits) begin
            status1 <= status1 & ~ir.dl; // RL16
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            port_out <= '0;
        end else if (in_exec && (op == `TMD_OP_OUT)) begin
            port_out[{ir.dh, 2'b00} +: 4] <= r_val; // RL19
        end else if (set_bits && is_port_bits) begin
            port_out[{ir.dh, 2'b00} +: 4] <= port_cur | ir.lo; // RL19
        end else if (clr_bits && is_port_bits) begin
            port_out[{ir.dh, 2'b00} +: 4] <= port_cur & ~ir.lo; // RL19
        end
    end

    // ----------------------------------------------------------------
    // Display and serial mode
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            segment_out <= '1;
            digit_out <= 2'h0;
        end else if (in_exec2 && (op == `TMD_OP_SEG)) begin
            segment_out <= seg_pat; // RL18
        end else if (in_exec && (op == `TMD_OP_DIG)) begin
            digit_out <= r_val[3:2]; // RL18
        end
    end

    wire ser_load = in_exec && (op == `TMD_OP_MISC) && (ir.dh == `TMD_HI_FALSE)
                    && (ir.dl == `TMD_SUB_ONE);

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            serial_mode <= `TMD_RST_NIB;
        end else if (ser_load) begin
            serial_mode <= {ir.lo[3], 1'b0, ir.lo[1:0]}; // RL20
        end
    end

    // ----------------------------------------------------------------
    // Synthesizer load
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            synth_load <= '0;
            synth_strobe <= 1'b0;
        end else begin
            synth_strobe <= in_exec && (op == `TMD_OP_SYN); // RL10
            if (in_exec && (op == `TMD_OP_SYN)) begin
                synth_load.divider <= div_nib; // RL10
                synth_load.freq_sel <= r_val;
                synth_load.mem_nib <= m_val;
            end
        end
    end
endmodule

// ---- bench/tmd_progmem.sv ----
// Program memory model answering instruction fetches
`timescale 1ns/1ps
module tmd_progmem import tmd_pkg::*; (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic slow,
    input wire logic prog_req,
    input wire logic [10:0] prog_addr,
    output logic prog_ack,
    output tmd_instr_t prog_data
);
    logic [15:0] mem [2048];
    logic tick;
    wire logic give = prog_req & ~prog_ack & (~slow | tick);
    // Data held only in the acked cycle, inverted otherwise
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            prog_ack <= 1'b0;
            tick <= 1'b0;
            prog_data <= '0;
        end else begin
            tick <= ~tick;
            prog_ack <= give;
            prog_data <= give ? mem[prog_addr] : ~prog_data;
        end
    end
endmodule

// ---- bench/tmd_decode_monitor.sv ----
// Port checks for the instruction decoder
`timescale 1ns/1ps
module tmd_decode_monitor import tmd_pkg::*; (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic prog_req,
    input wire logic prog_ack,
    input wire logic [10:0] prog_addr,
    input wire logic chip_enable,
    input wire logic timer_event,
    input wire logic unlock_event,
    input wire logic synth_strobe,
    input wire tmd_synth_t synth_load,
    input wire logic [1:0] digit_out,
    input wire logic timer_flag,
    input wire logic unlock_flag,
    input wire logic clock_stopped
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    chk_halt_needs_low: assert property ($rose(clock_stopped) |-> !$past(chip_enable))
        else $error("halt with enable high");
    chk_halt_holds: assert property (clock_stopped && !chip_enable |=> clock_stopped)
        else $error("early halt exit");
    chk_halt_no_fetch: assert property (clock_stopped |-> !prog_req)
        else $error("fetch while halted");
    chk_fetch_stands: assert property (prog_req && !prog_ack |=> prog_req && $stable(prog_addr))
        else $error("fetch dropped");
    chk_synth_pulse: assert property (synth_strobe |=> !synth_strobe)
        else $error("long synth strobe");
    chk_synth_only: assert property (!synth_strobe |-> $stable(synth_load))
        else $error("unstrobed synth load");
    chk_timer_set: assert property (timer_event |=> timer_flag)
        else $error("timer flag not set");
    chk_unlock_set: assert property (unlock_event |=> unlock_flag)
        else $error("unlock flag not set");
    chk_timer_cause: assert property ($rose(timer_flag) |-> $past(timer_event))
        else $error("timer flag set without event");
    chk_digit_exec: assert property (!$stable(digit_out) |-> !$past(prog_req))
        else $error("digit change outside exec");
endmodule
bind tmd_decode tmd_decode_monitor mon (.*);

// ---- bench/tmd_decode_tb.sv ----
// Self-checking bench for the instruction decoder
`timescale 1ns/1ps
module tmd_decode_tb import tmd_pkg::*; ;
    logic clk = 0, reset_n = 0, irq_n = 1, chip_enable = 1, interval_pulse = 0;
    logic timer_event = 0, unlock_event = 0, comp_above = 0, comp_below = 0, seg_group = 0;
    logic prog_req, prog_ack, synth_strobe, timer_flag, unlock_flag, clock_stopped, slow = 0;
    logic [7:0] shift_count = '0;
    logic [15:0] port_in = '0, port_out;
    logic [10:0] prog_addr;
    tmd_instr_t prog_data;
    logic [6:0] segment_out;
    logic [1:0] digit_out;
    logic [3:0] serial_mode, status1, a, b, c;
    tmd_synth_t synth_load;
    logic [31:0] r = 32'hC914;
    logic [15:0] prog [16];
    int mismatches = 0, n_compared = 0;
    function automatic logic [223:0] mk_seg();
        logic [223:0] t;
        for (int i = 0; i < 32; i++) t[7*i+:7] = 7'(i * 5 + 3);
        return t;
    endfunction
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    localparam logic [223:0] SEGT = mk_seg();
    localparam logic [15:0] SKW [18] = '{16'hB901, 16'hBD01, 16'hB501, 16'hB101, 16'h3900,
        16'h3D00, 16'h3500, 16'h3100, 16'h2D00, 16'h2900, 16'h2410, 16'h2010, 16'h2420,
        16'h2020, 16'hA210, 16'hA010, 16'hA000, 16'hA200};
    localparam logic [15:0] DTW [14] = '{16'h4D00, 16'h4500, 16'h4900, 16'h0010, 16'h9501,
        16'h9901, 16'hC101, 16'h9101, 16'hC501, 16'hCC21, 16'hC801, 16'hAD01, 16'h8001,
        16'h8501};
    tmd_decode #(.SEG_TABLE(SEGT)) uut (.*);
    tmd_progmem pm (.*);
    initial forever #2 clk = ~clk;
    function automatic logic es(input int k);
        logic [17:0] v;
        v = {comp_below, comp_above, shift_count[3:0] != 4'h8, shift_count[3:0] == 4'h8,
            !chip_enable, chip_enable, irq_n, !irq_n, (b & a) == 4'h0, (b & a) == a,
            b < a, b >= a, b != a, b == a, a < b, a >= b, a != b, a == b};
        return v[k];
    endfunction
    function automatic logic [7:0] ed(input int k);
        case (k)
            0: return {b & c, a};
            1: return {b | c, a};
            2: return {c, a};
            4: return {b, a ^ b};
            5: return {b, b};
            6: return {a, a};
            7: return {4'h0, a};
            8: return {a == 4'h0 ? b : 4'h0, a};
            9: return {b, a == 4'h1 ? 4'h0 : a};
            10: return {b, port_in[3:0]};
            default: return {b, a};
        endcase
    endfunction
    task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (e !== g) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic give_verdict();
        $display("Compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic rnd(input int it);
        repeat (5) r = lfsr(r);
        a = r[3:0];
        b = it == 0 ? r[3:0] : r[7:4];
        c = r[11:8];
        {irq_n, chip_enable, comp_above, comp_below, seg_group, slow} = r[17:12];
        shift_count = it[0] ? r[31:24] : {r[31:28], 4'h8};
        port_in = r[31:16];
        interval_pulse = r[18];
        for (int i = 0; i < 16; i++) prog[i] = '0;
        prog[0] = {12'h481, a};
        prog[1] = {12'h490, b};
    endtask
    task automatic start();
        @(negedge clk);
        reset_n = 0;
        for (int i = 0; i < 2048; i++) pm.mem[i] = '0;
        for (int i = 0; i < 16; i++) pm.mem[i] = prog[i];
        repeat (5) @(negedge clk);
        reset_n = 1;
    endtask
    task automatic finish(input logic [10:0] ea);
        int k;
        k = 0;
        while (!(prog_req === 1'b1 && prog_addr === ea) && k < 400) begin
            @(negedge clk);
            k++;
        end
        check("end address", 400, k == 400 ? 0 : 400);
        repeat (4) @(negedge clk);
    endtask
    initial begin
        #100000;
        mismatches++;
        give_verdict();
    end
    initial begin
        for (int k = 0; k < 18; k++) begin
            for (int it = 0; it < 4; it++) begin
                rnd(it);
                prog[2] = SKW[k] | {12'h000, (k > 3 && k < 10) ? a : 4'h0};
                {prog[3], prog[4], prog[5]} = {16'h0401, 16'h0501, 16'h1805};
                start();
                finish(11'h005);
                check("skip", {7'h08, ~es(k)}, port_out[7:0]);
            end
        end
        $display("skip tests done");
        for (int k = 0; k < 14; k++) begin
            for (int it = 0; it < 4; it++) begin
                rnd(it);
                prog[2] = DTW[k] | {12'h000, k < 4 ? c : 4'h0};
                {prog[3], prog[4]} = {16'h9902, 16'h8801};
                {prog[5], prog[6]} = {16'h8902, 16'h1806};
                start();
                finish(11'h006);
                check("data", ed(k), port_out[7:0]);
                if (k == 3) check("serial", {c[3], 1'b0, c[1:0]}, serial_mode);
                if (k == 11) check("synth", {12'h000, b, a, b}, synth_load);
                if (k == 12) check("digit", a[3:2], digit_out);
                if (k == 13) check("seg", 7'({seg_group, a == 4'h0 ? b : 4'h0} * 5 + 3), segment_out);
            end
        end
        $display("data tests done");
        rnd(1);
        {prog[0], prog[1], prog[2]} = {16'h1C08, 16'h0402, 16'h1C09};
        {prog[3], prog[4], prog[8], prog[9]} = {16'h0404, 16'h0805, 16'h1400, 16'h1000};
        start();
        pm.mem[11'h405] = 16'h0805;
        finish(11'h405);
        check("flow", 3'b100, port_out[2:0]);
        rnd(1);
        {prog[0], prog[1], prog[2]} = {16'h0440, 16'h0420, 16'h0410};
        {prog[3], prog[4], prog[5]} = {16'h0C20, 16'h2440, 16'h0401};
        {prog[6], prog[7], prog[8]} = {16'h0406, 16'h0C02, 16'h1808};
        start();
        finish(11'h008);
        check("status1", 4'h5, status1);
        check("port bits", 4'h4, port_out[3:0]);
        $display("flow and status tests done");
        for (int it = 0; it < 2; it++) begin
            rnd(1);
            interval_pulse = it[0];
            {prog[2], prog[3], prog[4]} = {16'hA410, 16'h0401, 16'hA410};
            {prog[5], prog[6], prog[7]} = {16'h0402, 16'hA800, 16'h0404};
            {prog[8], prog[9], prog[10]} = {16'hA400, 16'h0408, 16'h180A};
            start();
            timer_event = 1;
            unlock_event = 1;
            @(negedge clk);
            timer_event = 0;
            unlock_event = 0;
            finish(11'h00A);
            check("flag tests", {it[0], 3'b101}, port_out[3:0]);
            check("flags", 2'b00, {timer_flag, unlock_flag});
        end
        for (int ce = 0; ce < 2; ce++) begin
            rnd(1);
            chip_enable = 1'(ce);
            {prog[0], prog[1], prog[2]} = {16'h8CEE, 16'h0401, 16'h1802};
            start();
            repeat (10) @(negedge clk);
            check("stopped", ce == 0, clock_stopped);
            chip_enable = 1;
            finish(11'h002);
            check("resumed", 1'b1, port_out[0]);
        end
        $display("flag and halt tests done");
        give_verdict();
    end
endmodule
